// ### logic/eii_pkg.sv
// Function
// R1: Six external interrupt inputs, each filtered against short pulses.
// R2: Config bit picks shared pin role; 0 port, 1 interrupt zero; reset port.
// R3: Fast modes, inputs zero and five reject under 2, accept 7 periods.
// R4: Input one rejects under 63 (select 0) or 15 (select 1) periods.
// R5: Fast modes, inputs two to four reject under 7, accept 25 periods.
// R6: Slow modes, all inputs reject under 1, accept 3.5 slow periods.
// R7: Inputs one to three edge select 0 rising, 1 falling; zero, five falling.
// R8: Input four trigger: 00 rise, 01 fall, 10 both, 11 high level.
// R9: With shared pin as port, its falling edge never sets latch zero.
// R10: Clean edge sets latch within establishment time plus six fast periods.
// R11: Changed input one reject select applies within 64 fast periods.
// R12: Level mode on input four waits for a rising edge after reset.
// R13: Output use of shared pins can fake requests; software masks enables.
// R14: Software disables interrupts when switching clock or rewriting control.
// R15: Control register eight bits at 0x37, defined bits reset zero.
// R16: Software avoids read-modify-write on write-only registers and latches.
// R17: Request serviced only with master and source enables both set.
// R18: Filters are synchronous counters; in-between lengths go either way.
// R19: Detectors pulse a one-cycle set request per event into the latch; input four in level mode holds it while armed and high.
package eii_pkg;
   localparam int          NUM_SRC        = 6;
   localparam logic [5:0]  CTRL_ADDR      = 6'h37;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam int          BIT_ONE_REJ    = 7;
   localparam int          BIT_SHARED     = 6;
   localparam int          BIT_FOUR_LO    = 4;
   localparam int          BIT_THREE_ES   = 3;
   localparam int          BIT_TWO_ES     = 2;
   localparam int          BIT_ONE_ES     = 1;
   // Reject times in fast clock periods; the clock is the fast clock
   localparam int          REJ_FAST_PER   = 2;
   localparam int          REJ_MID_PER    = 7;
   localparam int          REJ_ONE_LONG   = 63;
   localparam int          REJ_ONE_SHORT  = 15;
   localparam int          CNT_W          = 6;
   localparam logic [5:0]  THR_FAST       = 6'(REJ_FAST_PER);
   localparam logic [5:0]  THR_MID        = 6'(REJ_MID_PER);
   localparam logic [5:0]  THR_ONE_LONG   = 6'(REJ_ONE_LONG);
   localparam logic [5:0]  THR_ONE_SHORT  = 6'(REJ_ONE_SHORT);
   // Slow modes: two agreeing slow ticks reject 1 and accept 3.5 periods
   localparam logic [5:0]  THR_SLOW_TICKS = 6'h02;
   localparam logic [1:0]  TRIG_RISE      = 2'h0;
   localparam logic [1:0]  TRIG_FALL      = 2'h1;
   localparam logic [1:0]  TRIG_BOTH      = 2'h2;
   localparam logic [1:0]  TRIG_HIGH      = 2'h3;
endpackage

// ### logic/eii_filter.sv
`timescale 1ns/10ps
module eii_filter #(
   parameter int W = eii_pkg::CNT_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Mode
   input  wire logic         slow_mode,
   input  wire logic         slow_tick,
   input  wire logic [W-1:0] thresh,
   // Pin and result
   input  wire logic         pin,
   output logic              filt_ff
);
   import eii_pkg::*;

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic         step;

   if (W < CNT_W) begin : g_chk
      $error("eii_filter: counter too narrow");
   end

   // Pulses idle high so no spurious edge comes out of reset
   assign step    = slow_mode ? slow_tick : 1'b1;
   assign nxt_cnt = cnt_ff + W'(1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (pin == filt_ff) begin
         cnt_ff <= '0;                               // [R18]
      end else if (step) begin
         cnt_ff <= (nxt_cnt >= thresh) ? '0 : nxt_cnt; // [R1]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_ff <= 1'b1;
      end else if (pin != filt_ff && step && nxt_cnt >= thresh) begin
         filt_ff <= pin;                             // [R6]
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   short_pulse_a: assert property (                  // [R1]
      $fell(pin) && filt_ff ##1
      pin [*3] ##1 1'b1 |-> filt_ff)
      else $error("short pulse passed the filter");
   fast_accept_a: assert property (                  // [R3]
      !slow_mode && thresh == 6'h02 && $fell(pin) && filt_ff ##1 !pin
      ##0 !slow_mode && thresh == 6'h02 |=> !filt_ff)
      else $error("two cycle pulse not accepted");
   change_cause_a: assert property (                 // [R18]
      $changed(filt_ff) |-> $past(pin) == filt_ff)
      else $error("filter moved away from its input");
endmodule

// ### logic/eii_top.sv
`timescale 1ns/10ps
module eii_top (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       arst_n,
   // Register port
   input  wire logic [5:0]                 sfr_addr,
   input  wire logic                       sfr_we,
   input  wire logic                       sfr_re,
   input  wire logic [7:0]                 sfr_wdata,
   output logic [7:0]                      sfr_rdata,
   // Operating mode
   input  wire logic                       slow_mode,
   input  wire logic                       low_freq_tick,
   // Pins
   input  wire logic [eii_pkg::NUM_SRC-1:0] ext_irq_pin,
   output logic                            shared_pin_irq_select,
   // Interrupt latches and enables
   input  wire logic                       master_irq_enable,
   input  wire logic [eii_pkg::NUM_SRC-1:0] source_enable_flag,
   input  wire logic [eii_pkg::NUM_SRC-1:0] latch_clear,
   output logic [eii_pkg::NUM_SRC-1:0]      irq_latch,
   output logic [eii_pkg::NUM_SRC-1:0]      irq_service_req
);
   import eii_pkg::*;

   logic                rst_meta_ff;
   logic                rst_sync_ff;
   logic [7:0]          ctrl_ff;
   logic [7:0]          rdata_ff;
   logic [NUM_SRC-1:0]  filt;
   logic [NUM_SRC-1:0]  filt_prev_ff;
   logic [NUM_SRC-1:0]  set_req;
   logic [NUM_SRC-1:0]  latch_ff;
   logic [CNT_W-1:0]    thr [NUM_SRC];
   logic                four_armed_ff;
   logic [NUM_SRC-1:0]  rise;
   logic [NUM_SRC-1:0]  fall;
   logic                ctrl_hit;

   // Reset release through two flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   function automatic logic edge_hit(input logic sel, input logic r,
                                     input logic f);
      edge_hit = sel ? f : r;
   endfunction

   // Control register
   assign ctrl_hit = (sfr_addr == CTRL_ADDR);

   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         ctrl_ff <= CTRL_RESET;                      // [R15]
      end else if (sfr_we && ctrl_hit) begin
         ctrl_ff <= {sfr_wdata[7:1], 1'b0};          // [R15]
      end
   end

   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         rdata_ff <= 8'h00;
      end else if (sfr_re && ctrl_hit) begin
         rdata_ff <= ctrl_ff;
      end else if (sfr_re) begin
         rdata_ff <= 8'h00;
      end
   end

   assign sfr_rdata             = rdata_ff;
   assign shared_pin_irq_select = ctrl_ff[BIT_SHARED];   // [R2]

   // Reject thresholds; a select change takes effect at once
   always_comb begin
      if (slow_mode) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            thr[i] = THR_SLOW_TICKS;                 // [R6]
         end
      end else begin
         thr[0] = THR_FAST;                          // [R3]
         thr[5] = THR_FAST;                          // [R3]
         thr[1] = ctrl_ff[BIT_ONE_REJ] ? THR_ONE_SHORT
                                       : THR_ONE_LONG; // [R4] [R11]
         thr[2] = THR_MID;                           // [R5]
         thr[3] = THR_MID;                           // [R5]
         thr[4] = THR_MID;                           // [R5]
      end
   end

   for (genvar g = 0; g < NUM_SRC; g++) begin : g_filt
      eii_filter #(
         .W         (CNT_W)
      ) u_filt (
         .clk       (clk),
         .rst_n     (rst_sync_ff),
         .slow_mode (slow_mode),
         .slow_tick (low_freq_tick),
         .thresh    (thr[g]),
         .pin       (ext_irq_pin[g]),
         .filt_ff   (filt[g])
      );
   end

   // Edge detection on filtered inputs
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         filt_prev_ff <= '1;
      end else begin
         filt_prev_ff <= filt;
      end
   end

   assign rise = filt & ~filt_prev_ff;
   assign fall = ~filt & filt_prev_ff;

   // Level mode needs a rising edge seen after reset
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         four_armed_ff <= 1'b0;
      end else if (rise[4]) begin
         four_armed_ff <= 1'b1;                      // [R12]
      end
   end

   always_comb begin
      set_req[0] = fall[0] & ctrl_ff[BIT_SHARED];    // [R7] [R9]
      set_req[1] = edge_hit(ctrl_ff[BIT_ONE_ES], rise[1], fall[1]); // [R7]
      set_req[2] = edge_hit(ctrl_ff[BIT_TWO_ES], rise[2], fall[2]); // [R7]
      set_req[3] = edge_hit(ctrl_ff[BIT_THREE_ES], rise[3],
                            fall[3]);                // [R7]
      case (ctrl_ff[BIT_FOUR_LO +: 2])
         TRIG_RISE: set_req[4] = rise[4];            // [R8]
         TRIG_FALL: set_req[4] = fall[4];            // [R8]
         TRIG_BOTH: set_req[4] = rise[4] | fall[4];  // [R8]
         default:   set_req[4] = filt[4] &
                                 (four_armed_ff | rise[4]); // [R8] [R12]
      endcase
      set_req[5] = fall[5];                          // [R7]
   end

   // Latches: a set in the clear cycle wins
   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         latch_ff <= '0;
      end else begin
         latch_ff <= (latch_ff & ~latch_clear) | set_req; // [R19] [R10]
      end
   end

   assign irq_latch       = latch_ff;
   assign irq_service_req = latch_ff & source_enable_flag &
                            {NUM_SRC{master_irq_enable}}; // [R17] [R13]

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_ff);

   latch_set_a: assert property (                    // [R19]
      |set_req |=> (latch_ff & $past(set_req)) == $past(set_req))
      else $error("set request did not reach the latch");
   set_wins_a: assert property (                     // [R19]
      set_req[0] && latch_clear[0] |=> latch_ff[0])
      else $error("clear beat a simultaneous set");
   port_mode_a: assert property (                    // [R9]
      !ctrl_ff[BIT_SHARED] && !latch_ff[0] |=> !latch_ff[0])
      else $error("port mode set latch zero");
   service_gate_a: assert property (                 // [R17]
      |irq_service_req |-> master_irq_enable &&
      (irq_service_req & ~source_enable_flag) == '0)
      else $error("request passed without enables");
   level_wait_a: assert property (                   // [R12]
      !four_armed_ff && !rise[4] |-> !(set_req[4] &&
      ctrl_ff[5:4] == TRIG_HIGH))
      else $error("level request before a rising edge");
   edge_latency_a: assert property (                 // [R10]
      !slow_mode && ctrl_ff[BIT_SHARED] && filt[0] &&
      !latch_clear[0] ##1 (!ext_irq_pin[0] && !slow_mode
      && !latch_clear[0]) [*3] |=> latch_ff[0])
      else $error("clean edge did not set latch in time");
   reject_select_a: assert property (                // [R4]
      !slow_mode && ctrl_ff[BIT_ONE_REJ] |-> thr[1] == 6'h0F)
      else $error("input one short reject not in force");
   reject_sel_upd_a: assert property (               // [R11]
      sfr_we && ctrl_hit && !slow_mode |=> slow_mode ||
      thr[1] == ($past(sfr_wdata[BIT_ONE_REJ]) ? 6'h0F : 6'h3F))
      else $error("reject select change not applied");
   ctrl_write_a: assert property (                   // [R15]
      sfr_we && ctrl_hit |=> ctrl_ff == {$past(sfr_wdata[7:1]), 1'b0})
      else $error("control write lost");
   slow_thr_a: assert property (                     // [R6]
      slow_mode |-> thr[2] == 6'h02 && thr[0] == 6'h02)
      else $error("slow mode threshold wrong");
   read_back_a: assert property (                    // [R15]
      sfr_re && ctrl_hit |=> sfr_rdata == $past(ctrl_ff))
      else $error("control read returned wrong data");
   read_other_a: assert property (                   // [R15]
      sfr_re && !ctrl_hit |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   latch_hold_a: assert property (                   // [R19]
      set_req == '0 && latch_clear == '0 |=> $stable(latch_ff))
      else $error("latch moved without a request");
   level_repeat_a: assert property (                 // [R8]
      ctrl_ff[5:4] == TRIG_HIGH && four_armed_ff && filt[4] |=> latch_ff[4])
      else $error("armed level input did not keep its latch set");

   zero_fire_c: cover property (set_req[0]);
   four_level_c: cover property (ctrl_ff[5:4] == TRIG_HIGH && set_req[4]);
   one_short_c: cover property (ctrl_ff[BIT_ONE_REJ] && set_req[1]);
   serviced_c: cover property (|irq_service_req);
endmodule

// ### dv/eii_pin_src.sv
`timescale 1ns/10ps
module eii_pin_src (
   // Clock
   input  wire logic       clk,
   // Pins towards the block
   output logic      [5:0] pins
);
   // Sources only ever drive; the shared pin stays an input
   initial pins = 6'h3F;
   // Low pulse of len cycles, changed only at falling edges
   task automatic low_pulse(input int idx, input int len);
      pins[idx] = 1'b0;
      repeat (len) @(negedge clk);
      pins[idx] = 1'b1;
   endtask
endmodule

// ### dv/external_interrupt_inputs_bench.sv
`timescale 1ns/10ps
module external_interrupt_inputs_bench;
   import eii_pkg::*;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic [5:0] sfr_addr = 6'h00;
   logic       sfr_we = 1'b0;
   logic       sfr_re = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic       slow_mode = 1'b0;
   logic       low_freq_tick = 1'b0;
   logic [5:0] pins;
   logic       shared_sel;
   logic       master_en = 1'b1;
   logic [5:0] src_en = 6'h3F;
   logic [5:0] clr = 6'h00;
   logic [5:0] latch;
   logic [5:0] svc;
   logic [7:0] rd;
   int         errors = 0;
   int         samples_checked = 0;
   int         cycles = 0;
   int         tick_cnt = 0;
   // Control, input, low length, latch after fall, latch after rise
   int rows [17][5] = '{'{8'h40,0,1,0,0}, '{8'h40,0,2,1,0},
      '{8'h00,0,5,0,0}, '{8'h00,5,2,1,0}, '{8'h00,5,1,0,0},
      '{8'h00,1,62,0,0}, '{8'h00,1,63,0,1}, '{8'h82,1,14,0,0},
      '{8'h82,1,15,1,0}, '{8'h04,2,6,0,0}, '{8'h04,2,7,1,0},
      '{8'h00,2,7,0,1}, '{8'h08,3,7,1,0}, '{8'h00,3,7,0,1},
      '{8'h00,4,7,0,1}, '{8'h10,4,7,1,0}, '{8'h20,4,7,1,1}};

   eii_pin_src eii_pin_src_i (.clk(clk), .pins(pins));
   eii_top eii_top_i (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
      .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .slow_mode(slow_mode),
      .low_freq_tick(low_freq_tick), .ext_irq_pin(pins),
      .shared_pin_irq_select(shared_sel), .master_irq_enable(master_en),
      .source_enable_flag(src_en), .latch_clear(clr),
      .irq_latch(latch), .irq_service_req(svc));

   always #5 clk = ~clk;

   // Slow clock stand-in: one tick every eight fast cycles
   always @(negedge clk) begin
      tick_cnt <= (tick_cnt == 7) ? 0 : tick_cnt + 1;
      low_freq_tick <= slow_mode && (tick_cnt == 7);
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Whole bytes only, never read-modify-write
   task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_we = 1'b1;
      @(negedge clk);
      sfr_we = 1'b0;
      // Idle cycle so a following call never re-raises the strobe at once
      @(negedge clk);
   endtask

   task automatic reg_rd(input logic [5:0] a);
      sfr_addr = a;
      sfr_re = 1'b1;
      @(negedge clk);
      sfr_re = 1'b0;
      rd = sfr_rdata;
      @(negedge clk);
   endtask

   task automatic clear_all();
      clr = 6'h3F;
      @(negedge clk);
      clr = 6'h00;
   endtask

   initial begin
      repeat (20) @(negedge clk);
      check({1'b0, shared_sel, latch}, 8'h00);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      reg_rd(CTRL_ADDR);
      check(rd, CTRL_RESET);
      reg_wr(CTRL_ADDR, 8'hFF);
      reg_rd(CTRL_ADDR);
      check(rd, 8'hFE);
      check({7'h00, shared_sel}, 8'h01);
      reg_wr(6'h36, 8'h00);
      reg_rd(6'h36);
      check(rd, 8'h00);
      reg_rd(CTRL_ADDR);
      check(rd, 8'hFE);
      // Level mode with the pin high since reset must stay quiet
      repeat (10) @(negedge clk);
      check({2'h0, latch}, 8'h00);
      eii_pin_src_i.low_pulse(4, 7);
      repeat (12) @(negedge clk);
      check({7'h00, svc[4]}, 8'h01);
      master_en = 1'b0;
      @(negedge clk);
      check({7'h00, svc[4]}, 8'h00);
      master_en = 1'b1;
      src_en = 6'h2F;
      @(negedge clk);
      check({7'h00, svc[4]}, 8'h00);
      src_en = 6'h3F;
      foreach (rows[r]) begin
         src_en = 6'h00;
         reg_wr(CTRL_ADDR, 8'(rows[r][0]));
         clear_all();
         src_en = 6'h3F;
         eii_pin_src_i.low_pulse(rows[r][1], rows[r][2]);
         repeat (2) @(negedge clk);
         check({7'h00, latch[rows[r][1]]}, 8'(rows[r][3]));
         check({7'h00, svc[rows[r][1]]}, 8'(rows[r][3]));
         clear_all();
         repeat (80) @(negedge clk);
         check({7'h00, latch[rows[r][1]]}, 8'(rows[r][4]));
      end
      // Slow mode: a short pulse is dropped, a long one is taken
      reg_wr(CTRL_ADDR, 8'h40);
      slow_mode = 1'b1;
      clear_all();
      eii_pin_src_i.low_pulse(0, 4);
      repeat (40) @(negedge clk);
      check({7'h00, latch[0]}, 8'h00);
      eii_pin_src_i.low_pulse(0, 28);
      repeat (4) @(negedge clk);
      check({7'h00, latch[0]}, 8'h01);
      slow_mode = 1'b0;
      repeat (40) @(negedge clk);
      // Mid-run reset must also forget the level-mode arming
      arst_n = 1'b0;
      @(negedge clk);
      check({1'b0, shared_sel, latch}, 8'h00);
      check(sfr_rdata, 8'h00);
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      reg_rd(CTRL_ADDR);
      check(rd, CTRL_RESET);
      reg_wr(CTRL_ADDR, 8'h30);
      repeat (10) @(negedge clk);
      check({7'h00, latch[4]}, 8'h00);
      eii_pin_src_i.low_pulse(4, 7);
      repeat (12) @(negedge clk);
      check({7'h00, latch[4]}, 8'h01);
      complete_run();
   end
endmodule
